// *** logic/addr_hold.sv ***
// halt delay pipeline: holds a one-bit request for a number of clocks
// assumes synchronous active-high reset on clk_sys
`timescale 1ns/100ps
module addr_hold
    import useq_pkg::*;
#(
    parameter int DEPTH = HALT_DELAY
)
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic req,
    output logic done
);
    logic [DEPTH-1:0] pipe_reg; // shift of pending request
    logic [DEPTH-1:0] pipe_next;

    // shift in the request each clock
    always_comb
    begin
        pipe_next = {pipe_reg[DEPTH-2:0], req};
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pipe_reg <= '0;
        end
        else
        begin
            pipe_reg <= pipe_next;
        end
    end

    assign done = pipe_reg[DEPTH-1];
endmodule

// *** logic/microprogram_address_sequencer.sv ***
// microprogram address sequencer: indirect counter, mapper, microaddress register
// assumes phase control, run logic and save register are outside; clk_sys is the state clock
// Functional notes
// - count indirect phases, flag the third
// - fetch phases hold counter preset
// - second clears low, third clears high
// - flag plus interrupt enters interrupt fetch
// - normal fetch maps to address 0000
// - interrupt fetch maps to address 0004
// - indirect phase maps to address 0014
// - execute phase decodes instruction bits
// - class from upper bits steers translation
// - macro addresses lowest strapped extension module
// - macro decode lands in jump table
// - micro jump uses bits 0-7,12,17
// - bits 12,17 module; 0-7 location
// - bus bits 0-3 modify jump target
// - address bits 9:8 select module
// - ten-bit register: load, increment, clear
// - active-low load on state clock
// - return loads from save register
// - increment needs load, run, no stepped jump
// - stepped conditional jump halts two clocks later
// - reset from power low or preset
// - indirect re-entry only without third flag
`timescale 1ns/100ps
module microprogram_address_sequencer
    import useq_pkg::*;
#(
    parameter logic [1:0] MACRO_MODULE = 2'h1    // strap: lowest extension module
)
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic normal_fetch_active,
    input wire logic interrupt_fetch_active,
    input wire logic set_interrupt_fetch,
    input wire logic set_indirect_phase,
    input wire logic set_execute_phase,
    input wire logic interrupt_pending,
    input wire logic indirect_operand,
    input wire logic jump_or_call_instr,
    input wire logic [15:0] instruction_register,
    input wire logic [23:0] microinstruction_register,
    input wire logic micro_jump_select,
    input wire logic bus_modify_jump,
    input wire logic [3:0] bus_low,
    input wire logic microaddress_load_n,
    input wire logic micro_subroutine_return,
    input wire logic [9:0] save_register,
    input wire logic instruction_word_load,
    input wire logic run_set,
    input wire logic single_cycle,
    input wire logic conditional_micro_jump,
    input wire logic power_on_normal,
    input wire logic panel_preset,
    output logic third_indirect_flag,
    output logic force_interrupt_fetch,
    output logic indirect_reentry_ok,
    output logic [9:0] microaddress_register,
    output logic [9:0] mapper_address,
    output logic [1:0] module_select,
    output logic microaddress_increment,
    output logic rom_inhibit,
    output logic halt_request
);
    // indirect counter: bit 0 clears on the second indirect, bit 1 on the third
    logic [1:0] ind_cnt_reg;    // preset to ones while fetching
    logic [1:0] ind_cnt_next;
    // microaddress register and its next value
    logic [9:0] uaddr_reg;    // drives the control store
    logic [9:0] uaddr_next;
    // mapper output, fed to the register on a load
    logic [9:0] map_addr;
    // control terms shared by several processes
    logic reset_n;    // active-low register clear
    logic stepped_jump;    // stepped conditional jump pending
    logic any_fetch;    // either fetch phase level
    logic count_step;    // an indirect set that may still count
    iclass_e iclass;    // execute class of the instruction word

    // execute class from opcode bits; memory reference when the group field is nonzero
    // shift-rotate and input/output words fall through to the first class block
    function automatic iclass_e classify(input logic [15:0] ir);
        iclass_e c;
        c = CLS_MEMSHIFT;
        if (ir[IR_GRP_HI:IR_GRP_LO] != GROUP_NONMEM)
        begin
            // memory reference words
            c = CLS_MEMSHIFT;
        end
        else if (ir[IR_SUB_HI:IR_SUB_LO] == SUB_ALTSKIP)
        begin
            // alter-skip words
            c = CLS_ALTSKIP;
        end
        else if (ir[IR_SUB_HI:IR_SUB_LO] == SUB_EXTARITH)
        begin
            // extended arithmetic words
            c = CLS_EXTARITH;
        end
        else if (ir[IR_SUB_HI:IR_SUB_LO] == SUB_MACRO)
        begin
            // user macro words, routed to an extension module
            c = CLS_MACRO;
        end
        return c;
    endfunction

    // start address inside a class block: block base ored with the offset field
    // used by every execute class, so the field slice lives in one place
    function automatic logic [7:0] block_start(input logic [7:0] base, input logic [15:0] ir);
        return base | {2'h0, ir[IR_OFF_HI:IR_OFF_LO]};
    endfunction

    // reset active when power not normal or preset pressed
    // the bench reset is folded in so one signal governs the clear
    // this clear leaves the indirect counter alone
    assign reset_n = ~(srst | ~power_on_normal | panel_preset);

    // third-indirect flag is the terminal count of the register, not a separate flop
    // held by the counter itself until a fetch presets it
    assign third_indirect_flag = (ind_cnt_reg == CNT_TERMINAL);
    // with the flag up a pending interrupt wins over another indirect
    assign force_interrupt_fetch = third_indirect_flag & interrupt_pending;
    // a jump or call with indirect operand may loop only below three
    assign indirect_reentry_ok = indirect_operand & jump_or_call_instr
        & ~third_indirect_flag;

    // either fetch level holds the counter preset
    assign any_fetch = normal_fetch_active | interrupt_fetch_active;
    // counting stops at the terminal state so the flag cannot wrap away
    assign count_step = set_indirect_phase & (ind_cnt_reg != CNT_TERMINAL);

    // counter next state; preset beats counting, so the first indirect is not counted
    always_comb
    begin
        // default: hold the count
        ind_cnt_next = ind_cnt_reg;
        if (any_fetch)
        begin
            // fetch phase active
            ind_cnt_next = CNT_PRESET;
        end
        else if (count_step)
        begin
            // clear low bit first, then high
            if (ind_cnt_reg[0])
            begin
                // second indirect in a row
                ind_cnt_next = {ind_cnt_reg[1], 1'b0};
            end
            else
            begin
                // third indirect in a row
                ind_cnt_next = CNT_TERMINAL;
            end
        end
    end

    // counter register; only reset and the next value reach it
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            // reset leaves the flag low
            ind_cnt_reg <= CNT_PRESET;
        end
        else
        begin
            // take the computed count
            ind_cnt_reg <= ind_cnt_next;
        end
    end

    // class of the word now in the instruction register
    assign iclass = classify(instruction_register);

    // mapper: phase start, execute decode, or micro jump target
    // a jump outranks the set-phase signals, which may still be up mid-phase
    always_comb
    begin
        // no set signal: normal fetch start
        map_addr = FETCH_START;
        if (micro_jump_select)
        begin
            // module from bits 17,12; location from bits 7:0
            map_addr = {microinstruction_register[MOD_HI_BIT],
                microinstruction_register[MOD_LO_BIT],
                microinstruction_register[JUMP_LOC_W-1:0]};
            // bus field only when the jump names the instruction as source
            if (bus_modify_jump)
            begin
                // only the low four bus bits reach the target
                map_addr[BUS_MOD_W-1:0] = bus_low;
            end
        end
        else if (set_interrupt_fetch & ~set_indirect_phase & ~set_execute_phase)
        begin
            // interrupt fetch alone
            map_addr = INT_FETCH_START;
        end
        else if (set_indirect_phase & ~set_interrupt_fetch & ~set_execute_phase)
        begin
            // indirect phase alone
            map_addr = INDIRECT_START;
        end
        else if (set_execute_phase & ~set_interrupt_fetch & ~set_indirect_phase)
        begin
            // start address from the offset field within the class block
            case (iclass)
                CLS_ALTSKIP:
                begin
                    // alter-skip block in module 0
                    map_addr = {MODULE_BASE, block_start(ALTSKIP_BASE, instruction_register)};
                end
                CLS_EXTARITH:
                begin
                    // extended arithmetic block in module 0
                    map_addr = {MODULE_BASE, block_start(EXTARITH_BASE, instruction_register)};
                end
                CLS_MACRO:
                begin
                    // lands in jump table of lowest extension module
                    map_addr = {MACRO_MODULE,
                        block_start(MACRO_BASE, instruction_register)};
                end
                default:
                begin
                    // memory reference and shift-rotate block in module 0
                    map_addr = {MODULE_BASE, block_start(MEMSHIFT_BASE, instruction_register)};
                end
            endcase
        end
    end

    // stepped conditional jump: inhibit rom now, halt two clocks later
    assign stepped_jump = conditional_micro_jump & single_cycle;
    // inhibited rom reads as all ones, a no-op in the next microinstruction
    assign rom_inhibit = stepped_jump;
    // no increment on a stepped jump, so the jump's own address is kept
    assign microaddress_increment = instruction_word_load & run_set
        & ~stepped_jump;

    // halt request trails the stepped jump by the halt delay
    // the pipe follows srst only; a panel clear does not cancel a pending halt
    addr_hold #(
        .DEPTH(HALT_DELAY)
    ) addr_hold_i (
        .clk_sys(clk_sys),
        .srst(srst),
        .req(stepped_jump),
        .done(halt_request)
    );

    // microaddress next: clear beats load beats increment
    always_comb
    begin
        // default: hold the address
        uaddr_next = uaddr_reg;
        if (!reset_n)
        begin
            // power not normal or preset pressed
            uaddr_next = ADDR_CLEAR;
        end
        else if (!microaddress_load_n)
        begin
            // return takes the saved address, else the mapper
            uaddr_next = micro_subroutine_return ? save_register : map_addr;
        end
        else if (microaddress_increment)
        begin
            // next sequential microinstruction; wraps at the top of module 3
            uaddr_next = uaddr_reg + ADDR_STEP;
        end
    end

    // microaddress register; the clear also follows srst here
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            // start of the normal fetch routine
            uaddr_reg <= ADDR_CLEAR;
        end
        else
        begin
            // take the computed address
            uaddr_reg <= uaddr_next;
        end
    end

    // register output straight from the flops
    assign microaddress_register = uaddr_reg;
    // mapper output shown for the phase logic and for test
    assign mapper_address = map_addr;
    // top two address bits pick the control-store module
    // a missing module is caught by logic outside this block
    assign module_select = uaddr_reg[MOD_SEL_HI:MOD_SEL_LO];
endmodule

// *** logic/useq_pkg.sv ***
// constants shared by the microprogram address sequencer
// assumes a single system clock; all fields are plain ports
package useq_pkg;
    localparam int ADDR_W = 10;
    localparam logic [9:0] FETCH_START = 10'h000;    // octal 0000
    localparam logic [9:0] INT_FETCH_START = 10'h004;    // octal 0004
    localparam logic [9:0] INDIRECT_START = 10'h00c;    // octal 0014
    localparam logic [9:0] ADDR_CLEAR = 10'h000;
    localparam logic [1:0] CNT_PRESET = 2'h3;
    localparam logic [1:0] CNT_TERMINAL = 2'h0;
    localparam logic [1:0] MODULE_BASE = 2'h0;
    localparam int MOD_HI_BIT = 17;
    localparam int MOD_LO_BIT = 12;
    localparam int JUMP_LOC_W = 8;
    localparam int BUS_MOD_W = 4;
    localparam logic [2:0] GROUP_NONMEM = 3'h0;    // group field of a non-memory word
    localparam logic [3:0] SUB_SHIFT = 4'h0;
    localparam logic [3:0] SUB_ALTSKIP = 4'h8;
    localparam logic [3:0] SUB_EXTARITH = 4'h4;
    localparam logic [3:0] SUB_MACRO = 4'hc;
    localparam logic [7:0] ALTSKIP_BASE = 8'h40;
    localparam logic [7:0] EXTARITH_BASE = 8'h80;
    localparam logic [7:0] MACRO_BASE = 8'hc0;
    localparam logic [7:0] MEMSHIFT_BASE = 8'h20;
    localparam int IR_GRP_HI = 14;    // group field of the instruction word
    localparam int IR_GRP_LO = 12;
    localparam int IR_SUB_HI = 11;    // subgroup field when the group is zero
    localparam int IR_SUB_LO = 8;
    localparam int IR_OFF_HI = 9;    // offset field within a class block
    localparam int IR_OFF_LO = 4;
    localparam int MOD_SEL_HI = 9;    // module bits of the microaddress
    localparam int MOD_SEL_LO = 8;
    localparam logic [9:0] ADDR_STEP = 10'h001;
    localparam int HALT_DELAY = 2;
    typedef enum logic [1:0] {CLS_MEMSHIFT, CLS_ALTSKIP, CLS_EXTARITH, CLS_MACRO} iclass_e;
endpackage

// *** tb/microprogram_address_sequencer_bench.sv ***
// self-checking bench for the microprogram address sequencer
// assumes the phase model stands in for the phase control logic
`timescale 1ns/100ps
module microprogram_address_sequencer_bench;
    logic clk_sys = '0, srst = '1, interrupt_pending = '1, indirect_operand = '1;
    logic jump_or_call_instr = '1, micro_jump_select = '0, bus_modify_jump = '0;
    logic microaddress_load_n = '1, micro_subroutine_return = '0, instruction_word_load = '1;
    logic run_set = '1, single_cycle = '0, conditional_micro_jump = '0;
    logic power_on_normal = '1, panel_preset = '0;
    logic [1:0] phase_now = '0, phase_next = '0, module_select;
    logic [3:0] bus_low = '0;
    logic [9:0] save_register = '0, microaddress_register, mapper_address;
    logic [15:0] instruction_register = '0;
    logic [23:0] microinstruction_register = '0;
    logic normal_fetch_active, interrupt_fetch_active, set_interrupt_fetch, set_indirect_phase;
    logic set_execute_phase, third_indirect_flag, force_interrupt_fetch, indirect_reentry_ok;
    logic microaddress_increment, rom_inhibit, halt_request;
    int n_errors = 0, total_checks = 0, cycles = 0;
    // three phase starts, then shift, mem-ref, skip, arith, macro words
    logic [15:0] ir_tab [8] = '{16'h0, 16'h0, 16'h0, 16'h0000, 16'h1230, 16'h0840, 16'h0410,
        16'h0c50};
    logic [9:0] ex_tab [8] = '{10'h000, 10'h004, 10'h00c, 10'h020, 10'h023, 10'h044, 10'h081,
        10'h2c5};
    // macro strap at 2, so the macro start shows a non-default module
    microprogram_address_sequencer #(
        .MACRO_MODULE(2'h2)
    ) microprogram_address_sequencer_i (
        .clk_sys(clk_sys),
        .srst(srst),
        .normal_fetch_active(normal_fetch_active),
        .interrupt_fetch_active(interrupt_fetch_active),
        .set_interrupt_fetch(set_interrupt_fetch),
        .set_indirect_phase(set_indirect_phase),
        .set_execute_phase(set_execute_phase),
        .interrupt_pending(interrupt_pending),
        .indirect_operand(indirect_operand),
        .jump_or_call_instr(jump_or_call_instr),
        .instruction_register(instruction_register),
        .microinstruction_register(microinstruction_register),
        .micro_jump_select(micro_jump_select),
        .bus_modify_jump(bus_modify_jump),
        .bus_low(bus_low),
        .microaddress_load_n(microaddress_load_n),
        .micro_subroutine_return(micro_subroutine_return),
        .save_register(save_register),
        .instruction_word_load(instruction_word_load),
        .run_set(run_set),
        .single_cycle(single_cycle),
        .conditional_micro_jump(conditional_micro_jump),
        .power_on_normal(power_on_normal),
        .panel_preset(panel_preset),
        .third_indirect_flag(third_indirect_flag),
        .force_interrupt_fetch(force_interrupt_fetch),
        .indirect_reentry_ok(indirect_reentry_ok),
        .microaddress_register(microaddress_register),
        .mapper_address(mapper_address),
        .module_select(module_select),
        .microaddress_increment(microaddress_increment),
        .rom_inhibit(rom_inhibit),
        .halt_request(halt_request)
    );
    useq_phase_model useq_phase_model_i (
        .phase_now(phase_now),
        .phase_next(phase_next),
        .normal_fetch_active(normal_fetch_active),
        .interrupt_fetch_active(interrupt_fetch_active),
        .set_interrupt_fetch(set_interrupt_fetch),
        .set_indirect_phase(set_indirect_phase),
        .set_execute_phase(set_execute_phase)
    );
    // 100 MHz state clock
    always #5 clk_sys = ~clk_sys;
    // hang guard, far above the few dozen cycles needed
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
            stop_test(1);
    end
    // compare, count and report
    task automatic ck(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // counts, verdict and end of run
    task automatic stop_test(input int fail);
        n_errors += fail;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // main sequence; inputs change only at rising edges
    initial
    begin
        @(posedge clk_sys);
        @(posedge clk_sys) srst <= '0;
        @(negedge clk_sys) ck(microaddress_register, 10'h000);
        ck(third_indirect_flag, 1'b0);
        $display("test reset done");
        // first indirect set meets an active fetch, then two more
        @(posedge clk_sys) phase_next <= 2'h2;
        @(posedge clk_sys) phase_now <= 2'h2;
        @(negedge clk_sys) ck(third_indirect_flag, 1'b0);
        @(negedge clk_sys) ck(third_indirect_flag, 1'b0);
        @(negedge clk_sys) ck(third_indirect_flag, 1'b1);
        ck(force_interrupt_fetch, 1'b1);
        ck(indirect_reentry_ok, 1'b0);
        @(negedge clk_sys) ck(third_indirect_flag, 1'b1);
        // interrupt fetch presets; with nothing pending no fetch is forced
        @(posedge clk_sys) phase_now <= 2'h1;
        interrupt_pending <= '0;
        @(negedge clk_sys) ck(force_interrupt_fetch, 1'b0);
        @(posedge clk_sys) interrupt_pending <= '1;
        @(negedge clk_sys) ck(force_interrupt_fetch, 1'b0);
        ck(indirect_reentry_ok, 1'b1);
        @(posedge clk_sys) jump_or_call_instr <= '0;
        @(negedge clk_sys) ck(indirect_reentry_ok, 1'b0);
        @(posedge clk_sys) jump_or_call_instr <= '1;
        $display("test counter done");
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_sys) phase_next <= (i < 3) ? 2'(i) : 2'h3;
            instruction_register <= ir_tab[i];
            @(negedge clk_sys);
            ck(mapper_address, ex_tab[i]);
        end
        ck(mapper_address, 10'h2c5);
        @(posedge clk_sys) micro_jump_select <= '1;
        microinstruction_register <= 24'h02_02a5;
        @(negedge clk_sys) ck(mapper_address, 10'h2a5);
        @(posedge clk_sys) bus_modify_jump <= '1;
        bus_low <= 4'h3;
        microaddress_load_n <= '0;
        @(negedge clk_sys) ck(mapper_address, 10'h2a3);
        @(negedge clk_sys) ck(microaddress_register, 10'h2a3);
        ck(module_select, 2'h2);
        @(posedge clk_sys) micro_subroutine_return <= '1;
        save_register <= 10'h3f1;
        @(posedge clk_sys) microaddress_load_n <= '1;
        @(negedge clk_sys) ck(microaddress_register, 10'h3f1);
        ck(module_select, 2'h3);
        @(negedge clk_sys) ck(microaddress_register, 10'h3f2);
        $display("test mapper and load done");
        // stepped conditional jump: no increment, halt two clocks on
        @(posedge clk_sys) conditional_micro_jump <= '1;
        single_cycle <= '1;
        @(negedge clk_sys) ck(rom_inhibit, 1'b1);
        ck(microaddress_increment, 1'b0);
        @(posedge clk_sys) conditional_micro_jump <= '0;
        @(negedge clk_sys) ck(halt_request, 1'b0);
        ck(microaddress_register, 10'h3f3);
        @(negedge clk_sys) ck(halt_request, 1'b1);
        // power low, then preset, each clears and counting resumes
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk_sys) power_on_normal <= i[0];
            panel_preset <= i[0];
            repeat (2) @(negedge clk_sys);
            ck(microaddress_register, 10'h000);
            @(posedge clk_sys) power_on_normal <= '1;
            panel_preset <= '0;
            repeat (2) @(negedge clk_sys);
            ck(microaddress_register, 10'h001);
        end
        $display("test address register done");
        stop_test(0);
    end
endmodule

// *** tb/microprogram_address_sequencer_chk.sv ***
// checker for the microprogram address sequencer
// assumes one clock clk_sys and synchronous active-high srst
`timescale 1ns/100ps
module microprogram_address_sequencer_chk
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic normal_fetch_active,
    input wire logic interrupt_fetch_active,
    input wire logic set_indirect_phase,
    input wire logic third_indirect_flag,
    input wire logic microaddress_load_n,
    input wire logic micro_subroutine_return,
    input wire logic [9:0] save_register,
    input wire logic [9:0] mapper_address,
    input wire logic [9:0] microaddress_register,
    input wire logic power_on_normal,
    input wire logic panel_preset,
    input wire logic conditional_micro_jump,
    input wire logic single_cycle,
    input wire logic rom_inhibit,
    input wire logic halt_request
);
    logic fetch; // either fetch phase
    logic ld; // parallel load with no clear
    logic hold_ok; // neither load nor clear
    assign fetch = normal_fetch_active || interrupt_fetch_active;
    assign ld = !microaddress_load_n && power_on_normal && !panel_preset;
    assign hold_ok = microaddress_load_n && power_on_normal && !panel_preset;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    chk_fetch_preset: assert property (fetch |=> !third_indirect_flag)
        else $error("flag kept over fetch");
    chk_flag_cause: assert property ($rose(third_indirect_flag) |->
        $past(set_indirect_phase)) else $error("flag rose unprompted");
    chk_flag_hold: assert property (third_indirect_flag && !fetch |=>
        third_indirect_flag) else $error("flag dropped");
    chk_load_map: assert property (ld && !micro_subroutine_return |=>
        microaddress_register == $past(mapper_address)) else $error("map load lost");
    chk_load_save: assert property (ld && micro_subroutine_return |=>
        microaddress_register == $past(save_register)) else $error("return load lost");
    chk_addr_clear: assert property (!power_on_normal || panel_preset |=>
        microaddress_register == 10'h000) else $error("address not cleared");
    chk_halt_delay: assert property (conditional_micro_jump && single_cycle |->
        ##2 halt_request) else $error("halt late");
    chk_inhibit_hold: assert property (rom_inhibit && hold_ok |=>
        $stable(microaddress_register)) else $error("address moved");
    cov_third: cover property ($rose(third_indirect_flag));
    cov_return: cover property (ld && micro_subroutine_return);
    cov_halt: cover property ($rose(halt_request));
endmodule

bind microprogram_address_sequencer microprogram_address_sequencer_chk
    microprogram_address_sequencer_chk_i (
    .clk_sys(clk_sys),
    .srst(srst),
    .normal_fetch_active(normal_fetch_active),
    .interrupt_fetch_active(interrupt_fetch_active),
    .set_indirect_phase(set_indirect_phase),
    .third_indirect_flag(third_indirect_flag),
    .microaddress_load_n(microaddress_load_n),
    .micro_subroutine_return(micro_subroutine_return),
    .save_register(save_register),
    .mapper_address(mapper_address),
    .microaddress_register(microaddress_register),
    .power_on_normal(power_on_normal),
    .panel_preset(panel_preset),
    .conditional_micro_jump(conditional_micro_jump),
    .single_cycle(single_cycle),
    .rom_inhibit(rom_inhibit),
    .halt_request(halt_request)
);

// *** tb/useq_phase_model.sv ***
// phase control stand-in: phase codes to phase levels and set signals
// assumes codes 0 fetch, 1 interrupt fetch, 2 indirect, 3 execute
`timescale 1ns/100ps
module useq_phase_model
(
    input wire logic [1:0] phase_now,
    input wire logic [1:0] phase_next,
    output logic normal_fetch_active,
    output logic interrupt_fetch_active,
    output logic set_interrupt_fetch,
    output logic set_indirect_phase,
    output logic set_execute_phase
);
    // current phase levels, one at a time
    assign normal_fetch_active = phase_now == 2'h0;
    assign interrupt_fetch_active = phase_now == 2'h1;
    // at most one set signal; none means normal fetch
    assign set_interrupt_fetch = phase_next == 2'h1;
    assign set_indirect_phase = phase_next == 2'h2;
    assign set_execute_phase = phase_next == 2'h3;
endmodule
